/* File: core/spi_cmd_pkg.sv */
// Shared constants and carriers for the serial EEPROM command front end.
// Assumes a single 125 MHz system clock; all pins are sampled into it.
package spi_cmd_pkg;
    // Instruction opcodes.
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD = 8'h03;
    localparam logic [7:0] OP_ARR_WR = 8'h02;
    localparam logic [7:0] OP_ID_RD = 8'h83;
    localparam logic [7:0] OP_ID_WR = 8'h82;
    // Address layout.
    localparam int ADDR_BITS = 24;
    localparam int ARR_MSB = 18;
    localparam int ID_MSB = 8;
    localparam int ID_SEL_BIT = 10;
    // Protected region starts (19-bit array address).
    localparam logic [18:0] QUARTER_BASE = 19'h6_0000;
    localparam logic [18:0] HALF_BASE = 19'h4_0000;
    // Status byte field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_PLO = 2;
    localparam int ST_PHI = 3;
    localparam int ST_LOCK = 7;
    // Self-timed write cycle length.
    localparam int WRITE_TIME_US = 5000;
    localparam int CLK_MHZ = 125;

    // Decoded command kinds.
    typedef enum logic [8:0] {
        K_NONE = 9'h001,
        K_SET = 9'h002,
        K_CLR = 9'h004,
        K_SRD = 9'h008,
        K_SWR = 9'h010,
        K_ARD = 9'h020,
        K_AWR = 9'h040,
        K_IRD = 9'h080,
        K_IWR = 9'h100
    } kind_e;

    // Front-end sequencing.
    typedef enum logic [3:0] {
        S_OPC = 4'h1,
        S_ADDR = 4'h2,
        S_DATA = 4'h4,
        S_WAIT = 4'h8
    } phase_e;

    // Write cycle request handed to the array engine.
    typedef struct packed {
        logic arr;
        logic swr;
        logic idw;
        logic idlock;
        logic [23:0] addr;
        logic [7:0] data;
    } wreq_s;

    // Nonvolatile status contents.
    typedef struct packed {
        logic lock;
        logic phi;
        logic plo;
    } nvstat_s;
endpackage

/* File: core/spi_pin_sync.sv */
// Two-flop synchroniser bank for the serial pins.
// Assumes every input is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module spi_pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second; reset value idles deselected.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '1;
            synced <= '1;
        end else begin
            meta_q <= pins;
            synced <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: core/spi_eeprom_command_protect.sv */
// Serial command front end of a byte-wide EEPROM: selection, pause,
// opcode and address decoding, write latch, protection and status readback.
// Assumes the serial clock is far slower than clk so every edge is seen.
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_command_protect
    import spi_cmd_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ,
    parameter logic [2:0] NV_INIT = 3'b000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic pause_n,
    input wire logic wprot_n,
    input wire logic [7:0] mem_rdata,
    output logic sdo,
    output logic sdo_oe,
    output logic standby,
    output logic mem_rd,
    output logic [23:0] mem_addr,
    output logic wr_start,
    output spi_cmd_pkg::wreq_s wr_req,
    output logic [7:0] status_byte
);
    import spi_cmd_pkg::*;

    // Refuse a write time that the cycle counter cannot serve, before any run starts.
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 32'h7FFF_FFFF) begin
        $error("WRITE_CYCLES out of range");
    end

    typedef struct packed {
        logic sclk_q;
        logic sel_q;
        logic paused;
        logic seen_fall;
        phase_e phase;
        kind_e kind;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [1:0] abyte;
        logic [23:0] addr;
        logic [7:0] data;
        logic have_data;
        logic done_edge;
        logic [7:0] tx;
        logic tx_on;
        logic latch;
        logic busy;
        logic [31:0] wcnt;
        wreq_s pend;
        nvstat_s nv;
        logic sdo;
        logic sdo_oe;
        logic standby;
        logic mem_rd;
        logic wr_start;
        logic [7:0] status;
    } state_s;

    state_s q, d;
    logic [4:0] syn;
    logic s_sel_n, s_sclk, s_sdi, s_pause_n, s_wp_n;

    spi_pin_sync #(.WIDTH(5)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pins({sel_n, sclk, sdi, pause_n, wprot_n}),
        .synced(syn)
    );
    assign {s_sel_n, s_sclk, s_sdi, s_pause_n, s_wp_n} = syn;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Opcode to command kind.
    function automatic kind_e decode(input logic [7:0] op);
        case (op)
            OP_SET_LATCH: decode = K_SET;
            OP_CLR_LATCH: decode = K_CLR;
            OP_STAT_RD: decode = K_SRD;
            OP_STAT_WR: decode = K_SWR;
            OP_ARR_RD: decode = K_ARD;
            OP_ARR_WR: decode = K_AWR;
            OP_ID_RD: decode = K_IRD;
            OP_ID_WR: decode = K_IWR;
            default: decode = K_NONE;
        endcase
    endfunction

    // True when an array address lies in the protected region.
    function automatic logic in_protect(input nvstat_s nv, input logic [18:0] a);
        case ({nv.phi, nv.plo})
            2'b01: in_protect = (a >= QUARTER_BASE);
            2'b10: in_protect = (a >= HALF_BASE);
            2'b11: in_protect = 1'b1;
            default: in_protect = 1'b0;
        endcase
    endfunction

    // Status byte image.
    function automatic logic [7:0] stat_img(input state_s s);
        stat_img = '0;
        stat_img[ST_BUSY] = s.busy;
        stat_img[ST_LATCH] = s.latch;
        stat_img[ST_PLO] = s.nv.plo;
        stat_img[ST_PHI] = s.nv.phi;
        stat_img[ST_LOCK] = s.nv.lock;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    logic rise, fall, sel_rise, sel_fall, active;
    logic [7:0] nsh;
    wreq_s req;
    logic ok_write;
    logic latch_set;

    always_comb begin
        d = q;
        d.sclk_q = s_sclk;
        d.sel_q = s_sel_n;
        d.wr_start = 1'b0;
        d.mem_rd = 1'b0;
        rise = s_sclk && !q.sclk_q;
        fall = !s_sclk && q.sclk_q;
        sel_fall = !s_sel_n && q.sel_q;
        sel_rise = s_sel_n && !q.sel_q;
        nsh = {q.sh[6:0], s_sdi};
        req = '0;
        ok_write = 1'b0;
        latch_set = 1'b0;

        // A falling select edge arms the front end after reset.
        if (sel_fall) begin
            d.seen_fall = 1'b1;
        end
        active = !s_sel_n && q.seen_fall;

        if (active && !q.paused && !s_pause_n && !s_sclk) begin
            d.paused = 1'b1;
        end else if (q.paused && s_pause_n && !s_sclk) begin
            d.paused = 1'b0;
        end

        if (active && !q.paused) begin
            if (rise) begin
                d.done_edge = 1'b0;
                d.bitc = q.bitc + 3'd1;
                d.sh = nsh;
                if (q.bitc == 3'd7) begin
                    d.done_edge = 1'b1;
                    case (q.phase)
                        S_OPC: begin
                            d.kind = decode(nsh);
                            case (decode(nsh))
                                K_ARD, K_AWR, K_IRD, K_IWR: d.phase = S_ADDR;
                                K_SWR: d.phase = S_DATA;
                                K_SRD: begin
                                    d.phase = S_DATA;
                                    d.tx = stat_img(q);
                                    d.tx_on = 1'b1;
                                end
                                default: d.phase = S_WAIT;
                            endcase
                        end
                        S_ADDR: begin
                            d.addr = {q.addr[15:0], nsh};
                            d.abyte = q.abyte + 2'd1;
                            if (q.abyte == 2'd2) begin
                                d.phase = S_DATA;
                                if (q.kind == K_ARD || q.kind == K_IRD) begin
                                    d.mem_rd = 1'b1;
                                    d.tx_on = 1'b1;
                                end
                            end
                        end
                        S_DATA: begin
                            d.data = nsh;
                            d.have_data = 1'b1;
                            if (q.kind == K_SRD) begin
                                d.tx = stat_img(q);
                            end else if (q.kind == K_ARD || q.kind == K_IRD) begin
                                d.addr = q.addr + 24'd1;
                                d.mem_rd = 1'b1;
                            end
                        end
                        default: d.phase = S_WAIT;
                    endcase
                end
            end else if (fall) begin
                // Clear the final-bit mark on a fall after a partial byte; a select rise after the final bit's fall is still accepted.
                if (q.bitc != 3'd0) begin
                    d.done_edge = 1'b0;
                end
                if (q.tx_on) begin
                    if (q.bitc == 3'd0) begin
                        d.sdo = (q.kind == K_SRD) ? q.tx[7] : mem_rdata[7];
                        d.tx = (q.kind == K_SRD) ? {q.tx[6:0], 1'b0}
                                                 : {mem_rdata[6:0], 1'b0};
                    end else begin
                        d.sdo = q.tx[7];
                        d.tx = {q.tx[6:0], 1'b0};
                    end
                end
            end
        end

        d.sdo_oe = active && q.tx_on && !q.paused;

        // Deselect: decide on execution, then reset command logic.
        if (sel_rise && q.seen_fall) begin
            // select rise inside final bit window
            // a complete write still launches from pause
            ok_write = (q.bitc == 3'd0) && (q.done_edge || q.paused);
            req.addr = q.addr;
            req.data = q.data;
            case (q.kind)
                K_SET: begin
                    if (ok_write && q.phase == S_ADDR) begin
                        d.latch = 1'b1;
                        latch_set = 1'b1;
                    end
                end
                K_CLR: begin
                    if (ok_write && q.phase == S_ADDR) begin
                        d.latch = 1'b0;
                    end
                end
                K_SWR: begin
                    req.swr = !(q.nv.lock && !s_wp_n);
                end
                K_AWR: begin
                    req.arr = !in_protect(q.nv, q.addr[ARR_MSB:0]);
                end
                K_IWR: begin
                    req.idlock = q.addr[ID_SEL_BIT];
                    req.idw = !q.addr[ID_SEL_BIT];
                    req.addr = q.addr[ID_SEL_BIT] ? '0 : {15'd0, q.addr[ID_MSB:0]};
                end
                default: ;
            endcase
            if (ok_write && q.have_data && q.latch && !q.busy
                && (req.arr || req.swr || req.idw || req.idlock)) begin
                d.pend = req;
                d.wr_start = 1'b1;
                d.busy = 1'b1;
                d.wcnt = '0;
            end
        end
        // reset command logic, keep latch and busy
        if (s_sel_n) begin
            d.paused = 1'b0;
            d.phase = S_OPC;
            d.kind = K_NONE;
            d.bitc = '0;
            d.abyte = '0;
            d.have_data = 1'b0;
            d.done_edge = 1'b0;
            d.tx_on = 1'b0;
        end
        // The opcode phase of latch commands waits for deselect.
        if (q.phase == S_OPC && (d.kind == K_SET || d.kind == K_CLR)) begin
            d.phase = S_ADDR;
        end

        // Self-timed write cycle.
        if (q.busy) begin
            d.wcnt = q.wcnt + 32'd1;
            if (q.wcnt == WRITE_CYCLES - 1) begin
                d.busy = 1'b0;
                // completion clears latch; a set in the same cycle wins.
                if (!latch_set) begin
                    d.latch = 1'b0;
                end
                if (q.pend.swr) begin
                    d.nv.lock = q.pend.data[ST_LOCK];
                    d.nv.phi = q.pend.data[ST_PHI];
                    d.nv.plo = q.pend.data[ST_PLO];
                end
            end
        end

        d.standby = s_sel_n && !d.busy;
        d.status = stat_img(d);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.sclk_q <= 1'b1; // Matches the synchroniser's reset, so no false rise.
            q.sel_q <= 1'b1;
            q.phase <= S_OPC;
            q.kind <= K_NONE;
            q.nv <= NV_INIT;
            q.standby <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flops.
    assign sdo = q.sdo;
    assign sdo_oe = q.sdo_oe;
    assign standby = q.standby;
    assign mem_rd = q.mem_rd;
    assign mem_addr = q.addr;
    assign wr_start = q.wr_start;
    assign wr_req = q.pend;
    assign status_byte = q.status;
endmodule
`default_nettype wire

/* File: tb/spi_cmd_protect_monitor.sv */
// Concurrent checks on the ports of the serial EEPROM command front end.
// Assumes the serial clock runs far slower than clk, as the bench drives it.
`timescale 1ns/1ns
`default_nettype none
module spi_cmd_protect_monitor #(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic pause_n,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic standby,
    input wire logic wr_start,
    input wire logic [7:0] status_byte
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;

    ////////////////////////////////////////////////////////////////////////
    // Length of the current busy stretch, so its end can be timed to within one cycle.
    always_comb busy_cnt_d = status_byte[0] ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            busy_cnt_q <= 32'h0000_0000;
        else
            busy_cnt_q <= busy_cnt_d;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_active;
        (!sel_n) [*4] |-> !standby;
    endproperty
    a_active: assert property (p_active) else $error("standby while selected");
    property p_busy_awake;
        status_byte[0] |-> !standby;
    endproperty
    a_busy_awake: assert property (p_busy_awake) else $error("standby while busy");
    property p_start_latch;
        wr_start |-> status_byte[1] && sel_n;
    endproperty
    a_start_latch: assert property (p_start_latch) else $error("write without latch");
    property p_start_busy;
        wr_start |-> ##[0:2] status_byte[0];
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("write not busy");
    property p_busy_len;
        $fell(status_byte[0]) |-> busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_latch_clear;
        $fell(status_byte[0]) |-> ##[0:1] !status_byte[1];
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch kept after write");
    property p_pause_float;
        (!pause_n && !sel_n) [*5] |-> !sdo_oe;
    endproperty
    a_pause_float: assert property (p_pause_float) else $error("output driven in pause");
    property p_sdo_hold;
        sclk [*3] |-> $stable(sdo);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("output moved in clock high");
endmodule

bind spi_eeprom_command_protect spi_cmd_protect_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_mon (
    .clk(clk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk), .pause_n(pause_n), .sdo(sdo),
    .sdo_oe(sdo_oe), .standby(standby), .wr_start(wr_start), .status_byte(status_byte));
`default_nettype wire

/* File: tb/spi_master_model.sv */
// Behavioural serial bus master for the EEPROM command front end.
// Assumes the bench clk of 8 ns; one serial clock period is 8 cycles.
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
    input wire logic clk,
    input wire logic sdo,
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    output logic pause_n
);
    // Quiet bus: deselected, clock low outside frames, pause released.
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        pause_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic select();
        @(posedge clk);
        sel_n <= 1'b0;
        tick(4);
    endtask
    // select rises in the high phase of the final bit when fin is set.
    task automatic xfer(input logic [7:0] tx, input int nbits, input bit fin,
                        output logic [7:0] rx);
        for (int i = 7; i > 7 - nbits; i--) begin
            sdi <= tx[i];
            tick(4);
            rx = {rx[6:0], sdo};
            sclk <= 1'b1;
            tick(2);
            if (fin && i == 8 - nbits) sel_n <= 1'b1;
            tick(2);
            sclk <= 1'b0;
        end
    endtask
    // pause only while selected and with the clock low
    // Clock pulses while paused are noise the device must ignore.
    task automatic hold(input int pulses);
        tick(2);
        pause_n <= 1'b0;
        repeat (pulses) begin
            tick(4);
            sclk <= 1'b1;
            sdi <= ~sdi;
            tick(4);
            sclk <= 1'b0;
        end
        tick(4);
        pause_n <= 1'b1;
        tick(2);
    endtask
    // Deselects in the middle of a pause.
    task automatic abort();
        tick(2);
        pause_n <= 1'b0;
        tick(4);
        sel_n <= 1'b1;
        tick(4);
        pause_n <= 1'b1;
        idle();
    endtask
    // A released data line shows the inverse of its last bit, never a stale value.
    task automatic idle();
        @(posedge clk);
        sel_n <= 1'b1;
        sdi <= ~sdi;
        tick(12);
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the serial EEPROM command front end.
// Assumes the master model drives the pins and the array returns a fixed byte.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import spi_cmd_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wprot_n = 1'b1;
    logic sel_n, sclk, sdi, pause_n, sdo, sdo_oe, standby, mem_rd, wr_start;
    logic [23:0] mem_addr;
    logic [7:0] status_byte, rx;
    wreq_s wr_req, last_req;
    int failures = 0;
    int n_checks = 0;
    int n_starts = 0;
    int n_reads = 0;

    always #4 clk = ~clk;
    spi_eeprom_command_protect #(.WRITE_CYCLES(400), .NV_INIT(3'b000)) i_dut (
        .clk(clk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .pause_n(pause_n),
        .wprot_n(wprot_n), .mem_rdata(8'ha5), .sdo(sdo), .sdo_oe(sdo_oe), .standby(standby),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .wr_start(wr_start), .wr_req(wr_req),
        .status_byte(status_byte));
    spi_master_model i_master (.clk(clk), .sdo(sdo), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
        .pause_n(pause_n));
    // Counts launched write cycles and array reads, keeps the last request.
    always @(posedge clk) begin
        if (wr_start === 1'b1) begin
            n_starts++;
            last_req <= wr_req;
        end
        if (mem_rd === 1'b1) begin
            n_reads++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input logic [39:0] v, input int n, input bit fin);
        i_master.select();
        for (int k = n - 1; k >= 0; k--) i_master.xfer(v[8*k +: 8], 8, fin && k == 0, rx);
        if (fin) i_master.idle();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 600 && status_byte[0] !== 1'b0; i++) @(posedge clk);
        check("busy", status_byte[0], 1'b0);
    endtask
    // Sends one command and compares the number of launched write cycles.
    task automatic cmd(input logic [39:0] v, input int n, input int exp);
        int s0;
        s0 = n_starts;
        frame(v, n, 1'b1);
        check("launch", n_starts - s0, exp);
        wait_idle();
    endtask
    task automatic latch();
        frame({32'h0, OP_SET_LATCH}, 1, 1'b1);
    endtask
    task automatic rd_status(input logic [7:0] exp);
        frame({24'h0, OP_STAT_RD, 8'h00}, 2, 1'b1);
        check("status read", rx, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_latch();
        check("standby", {standby, status_byte, sdo_oe}, 10'h200);
        rd_status(8'h00);
        latch();
        check("latch", status_byte, 8'h02);
        rd_status(8'h02);
        frame({32'h0, OP_CLR_LATCH}, 1, 1'b1);
        check("cleared", status_byte, 8'h00);
        frame({24'h0, 8'hff, OP_SET_LATCH}, 2, 1'b1);
        check("unknown", status_byte, 8'h00);
        i_master.select();
        i_master.xfer(OP_SET_LATCH, 8, 1'b0, rx);
        i_master.xfer(8'h00, 1, 1'b1, rx);
        i_master.idle();
        check("ninth pulse", status_byte, 8'h00);
    endtask
    task automatic t_write();
        cmd({OP_ARR_WR, 24'hf8_1234, 8'h5a}, 5, 0);
        latch();
        frame({OP_ARR_WR, 24'hf8_1234, 8'h5a}, 5, 1'b1);
        check("awake", standby, 1'b0);
        rd_status(8'h03);
        check("req", {last_req.arr, last_req.addr[18:0], last_req.data}, {1'b1, 19'h0_1234, 8'h5a});
        wait_idle();
        check("done", {standby, status_byte}, 9'h100);
    endtask
    task automatic t_protect();
        logic [18:0] a [4];
        a = '{19'h3_ffff, 19'h4_0000, 19'h5_ffff, 19'h6_0000};
        for (int c = 0; c < 4; c++) begin
            latch();
            cmd({24'h0, OP_STAT_WR, 4'h0, c[1:0], 2'b00}, 2, 1);
            check("size", status_byte[3:2], c[1:0]);
            for (int j = 0; j < 4; j++) begin
                latch();
                cmd({OP_ARR_WR, 5'h0, a[j], 8'h3c}, 5,
                    !(c == 3 || (c == 2 && j > 0) || (c == 1 && j == 3)));
            end
        end
    endtask
    task automatic t_lock();
        latch();
        cmd({24'h0, OP_STAT_WR, 8'h80}, 2, 1);
        wprot_n <= 1'b0;
        latch();
        cmd({24'h0, OP_STAT_WR, 8'h0c}, 2, 0);
        check("locked", status_byte, 8'h82);
        wprot_n <= 1'b1;
        cmd({24'h0, OP_STAT_WR, 8'h00}, 2, 1);
        check("unlocked", status_byte, 8'h00);
    endtask
    task automatic t_pause();
        latch();
        frame({8'h0, OP_ARR_WR, 24'h00_0000}, 4, 1'b0);
        i_master.xfer(8'hc3, 4, 1'b0, rx);
        i_master.hold(3);
        i_master.xfer(8'h30, 4, 1'b1, rx);
        i_master.idle();
        check("paused data", last_req.data, 8'hc3);
        wait_idle();
        latch();
        frame({OP_ARR_WR, 24'h00_0000, 8'h77}, 5, 1'b0);
        i_master.abort();
        check("abort launch", last_req.data, 8'h77);
        wait_idle();
        latch();
        frame({24'h0, OP_ARR_WR, 8'h00}, 2, 1'b0);
        i_master.abort();
        check("abort keeps", status_byte, 8'h02);
        // A status read paused mid-byte must resume at the bit where it stopped.
        i_master.select();
        i_master.xfer(OP_STAT_RD, 8, 1'b0, rx);
        i_master.xfer(8'h00, 4, 1'b0, rx);
        i_master.hold(2);
        i_master.xfer(8'h00, 4, 1'b1, rx);
        i_master.idle();
        check("paused read", rx[3:0], 4'h2);
        frame({32'h0, OP_CLR_LATCH}, 1, 1'b1);
    endtask
    task automatic t_ident();
        int r0;
        latch();
        cmd({OP_ID_WR, 24'h00_01ff, 8'h11}, 5, 1);
        check("id", {last_req.idw, last_req.idlock, last_req.addr[8:0]}, {2'b10, 9'h1ff});
        latch();
        cmd({OP_ID_WR, 24'h00_0400, 8'h11}, 5, 1);
        check("id lock", {last_req.idw, last_req.idlock}, 2'b01);
        r0 = n_reads;
        frame({OP_ARR_RD, 24'h00_0010, 8'h00}, 5, 1'b1);
        check("read", rx, 8'ha5);
        check("reads", n_reads - r0, 2);
        check("read addr", mem_addr, 24'h00_0011);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence after a five-cycle reset.
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        t_latch();
        t_write();
        t_protect();
        t_lock();
        t_pause();
        t_ident();
        print_verdict();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
